// File: inc/jss_pkg.sv
// Package of constants and types for the JESD sync input select block.
package jss_pkg;

  // ----------------------------------------
  // Selection and enable encodings
  // ----------------------------------------
  localparam logic SYNC_SEL_SINGLE = 1'h0;
  localparam logic SYNC_SEL_DIFF = 1'h1;
  localparam logic TS_RECV_ON = 1'h1;

  // ----------------------------------------
  // Reset values and sizes
  // ----------------------------------------
  localparam int SYNC_STAGES = 3;
  localparam logic SYNC_RESET_LEVEL = 1'h1;
  localparam int SYSREF_DIV_W = 8;
  localparam logic [7:0] SYSREF_DIV_RESET = 8'h00;
  localparam int ILAS_LEN = 4;
  localparam logic [7:0] ILAS_CNT_RESET = 8'h00;

  // ----------------------------------------
  // Link start-up states
  // ----------------------------------------
  typedef enum logic [1:0] {
    JSS_IDLE,
    JSS_CGS,
    JSS_ILAS,
    JSS_DATA
  } jss_state_t;

endpackage

// File: hdl/jss_sync_stage.sv
// Multi-stage level synchroniser for the sync request.
`timescale 1ns/1ps
module jss_sync_stage
  import jss_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic level_i,
  output logic level_o
);

  logic [STAGES-1:0] chain_q;

  // ----------------------------------------
  // Shift chain
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      chain_q <= {STAGES{SYNC_RESET_LEVEL}};
    end else begin
      chain_q <= {chain_q[STAGES-2:0], level_i};
    end
  end

  assign level_o = chain_q[STAGES-1];

endmodule

// File: hdl/jss_sync_select.sv
// Sync source selection and 8b/10b link start-up sequencing.
`timescale 1ns/1ps
// What this block does
// R01: Select 0 takes the sync request from the single-ended active-low pin.
// R02: Sync low from the receiver starts code group synchronization on all lanes.
// R03: Lane alignment starts only after sync returns high following code group sync.
// R04: Select 1 takes the sync request from the differential timestamp pair.
// R05: Serial read output is high impedance except during a serial register read.
// R06: Rising SYSREF edges mark the timing reference for deterministic latency.
// R07: The differential pair carries sync with active-low polarity as well.
// R08: Timestamp pair is usable only with its receiver enable set to 1.
// R09: The selected sync level passes a multi-stage synchroniser before use.
module jss_sync_select
  import jss_pkg::*;
#(
  parameter int ILAS_CYCLES = ILAS_LEN
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sync_select_i,
  input wire logic timestamp_receiver_enable_i,
  input wire logic timestamp_enable_i,
  input wire logic single_ended_sync_n_i,
  input wire logic diff_timestamp_pair_i,
  input wire logic sysref_i,
  input wire logic serial_read_active_i,
  input wire logic serial_read_bit_i,
  output logic cgs_active_o,
  output logic ilas_active_o,
  output logic link_data_o,
  output logic sysref_mark_o,
  output logic timestamp_o,
  output logic serial_read_output_o,
  output logic serial_read_output_oe_o
);

  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  logic ts_usable;
  logic sync_raw_n;
  logic sync_n;
  logic [7:0] ilas_cnt_q;
  logic sysref_q;
  jss_state_t state_q;
  jss_state_t state_d;
  logic ilas_done;

  // ----------------------------------------
  // State decoding
  // ----------------------------------------
  // Tells whether a state equals the wanted one.
  function automatic logic in_state(input jss_state_t now, input jss_state_t want);
    return now == want;
  endfunction

  // The pair counts only while its receiver is powered.
  assign ts_usable = (timestamp_receiver_enable_i == TS_RECV_ON); // R08

  // The selected level is still raw and may change at any edge.
  always_comb begin
    if (sync_select_i == SYNC_SEL_DIFF) begin
      // An unpowered receiver reads as released high.
      sync_raw_n = ts_usable ? diff_timestamp_pair_i : 1'b1; // R04 R07 R08
    end else begin
      sync_raw_n = single_ended_sync_n_i; // R01
    end
  end

  // ----------------------------------------
  // Synchroniser
  // ----------------------------------------
  jss_sync_stage #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .level_i(sync_raw_n),
    .level_o(sync_n)
  ); // R09

  // ----------------------------------------
  // Start-up sequence
  // ----------------------------------------
  // A low sync in alignment or data restarts code group synchronization.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      JSS_IDLE: begin
        if (!sync_n) begin
          state_d = JSS_CGS; // R02
        end
      end
      JSS_CGS: begin
        if (sync_n) begin
          state_d = JSS_ILAS; // R03
        end
      end
      JSS_ILAS: begin
        if (!sync_n) begin
          state_d = JSS_CGS; // R02
        end else if (ilas_done) begin
          state_d = JSS_DATA;
        end
      end
      JSS_DATA: begin
        if (!sync_n) begin
          state_d = JSS_CGS; // R02
        end
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // The register holds the link start-up state.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_q <= JSS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Lane alignment counter
  // ----------------------------------------
  assign ilas_done = (ilas_cnt_q == 8'(ILAS_CYCLES - 1));

  // The count restarts whenever the next state leaves alignment.
  always_ff @(posedge mclk_i) begin
    if (reset_i || !in_state(state_d, JSS_ILAS)) begin
      ilas_cnt_q <= ILAS_CNT_RESET;
    end else if (in_state(state_q, JSS_ILAS)) begin
      ilas_cnt_q <= ilas_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------
  // Link status outputs
  // ----------------------------------------
  // Outputs follow the next state so they line up with the state register.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cgs_active_o <= 1'b0;
    end else begin
      cgs_active_o <= in_state(state_d, JSS_CGS); // R02
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ilas_active_o <= 1'b0;
    end else begin
      ilas_active_o <= in_state(state_d, JSS_ILAS); // R03
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      link_data_o <= 1'b0;
    end else begin
      link_data_o <= in_state(state_d, JSS_DATA);
    end
  end

  // ----------------------------------------
  // SYSREF reference and timestamp
  // ----------------------------------------
  // The previous SYSREF level finds its rising edge.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sysref_q <= 1'b0;
    end else begin
      sysref_q <= sysref_i;
    end
  end

  // A mark is one cycle wide on each rising SYSREF edge.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sysref_mark_o <= 1'b0;
    end else begin
      sysref_mark_o <= sysref_i && !sysref_q; // R06
    end
  end

  // ----------------------------------------
  // Timestamp
  // ----------------------------------------
  // The timestamp reads the pair active low, as the sync does.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      timestamp_o <= 1'b0;
    end else begin
      timestamp_o <= ts_usable && timestamp_enable_i && !diff_timestamp_pair_i; // R08
    end
  end

  // ----------------------------------------
  // Serial read output
  // ----------------------------------------
  // Data is held low while the pin is released.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      serial_read_output_o <= 1'b0;
    end else begin
      serial_read_output_o <= serial_read_active_i ? serial_read_bit_i : 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      serial_read_output_oe_o <= 1'b0;
    end else begin
      serial_read_output_oe_o <= serial_read_active_i; // R05
    end
  end

endmodule

// File: sim/jss_sync_select_checker.sv
// Assertions on the ports of the sync select block.
`timescale 1ns/1ps
module jss_sync_select_checker #(
  parameter int ILAS_CYCLES = 4
) (
  input logic mclk_i, reset_i, sync_select_i, timestamp_receiver_enable_i, timestamp_enable_i,
  input logic single_ended_sync_n_i, diff_timestamp_pair_i, sysref_i, serial_read_active_i,
  input logic serial_read_bit_i, cgs_active_o, ilas_active_o, link_data_o, sysref_mark_o,
  input logic timestamp_o, serial_read_output_o, serial_read_output_oe_o
);
  logic sel;
  assign sel = sync_select_i ? (!timestamp_receiver_enable_i || diff_timestamp_pair_i) : single_ended_sync_n_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_cgs_entry: assert property ($rose(cgs_active_o) |-> !$past(sel, 4)) else $error("bad cgs");
  a_ilas_entry: assert property ($rose(ilas_active_o) |-> $past(sel, 4) && $past(cgs_active_o)) else $error("bad ilas");
  a_ilas_len: assert property ($rose(ilas_active_o) |-> ilas_active_o[*4] ##1 link_data_o) else $error("bad len");
  a_one_state: assert property ($onehot0({cgs_active_o, ilas_active_o, link_data_o})) else $error("bad state");
  a_read_idle: assert property (!$past(serial_read_active_i) |-> !serial_read_output_oe_o) else $error("bad oe");
  a_read_drive: assert property ($past(serial_read_active_i) |->
    serial_read_output_oe_o && serial_read_output_o == $past(serial_read_bit_i)) else $error("bad read");
  a_mark_src: assert property ($rose(sysref_i) |-> ##[1:3] sysref_mark_o) else $error("bad mark");
  a_ts_gate: assert property (timestamp_o |->
    $past(timestamp_enable_i && timestamp_receiver_enable_i && !diff_timestamp_pair_i)) else $error("bad ts");
  cover property ($rose(link_data_o));
  cover property ($rose(serial_read_output_oe_o));
  cover property ($rose(timestamp_o));
endmodule
bind jss_sync_select jss_sync_select_checker #(.ILAS_CYCLES(ILAS_CYCLES)) chk_inst (.*);

// File: sim/jss_rx_model.sv
// Receiver model that requests link sync and releases it after code group sync.
`timescale 1ns/1ps
module jss_rx_model (
  input logic mclk_i, request_i, cgs_active_i,
  output logic sync_n_o
);
  logic got_q = 1'h0;
  initial sync_n_o = 1'h1;
  always @(posedge mclk_i) begin
    got_q <= request_i && (got_q || cgs_active_i);
    sync_n_o <= !request_i || got_q || cgs_active_i;
  end
endmodule

// File: sim/testbench.sv
// Self-checking bench for the sync select block.
`timescale 1ns/1ps
module testbench;
  logic mclk_i = 0, reset_i = 1, sync_select_i = 0, timestamp_receiver_enable_i = 0, timestamp_enable_i = 0;
  logic sysref_i = 0, serial_read_active_i = 0, serial_read_bit_i = 0, req = 0, pin = 1, snc;
  logic single_ended_sync_n_i, diff_timestamp_pair_i, cgs_active_o, ilas_active_o, link_data_o;
  logic sysref_mark_o, timestamp_o, serial_read_output_o, serial_read_output_oe_o;
  int n_fail = 0, total_checks = 0;
  assign single_ended_sync_n_i = snc & !sync_select_i;
  assign diff_timestamp_pair_i = snc & pin;
  jss_sync_select #(.ILAS_CYCLES(4)) jss_sync_select_inst (.*);
  jss_rx_model jss_rx_model_inst (.mclk_i(mclk_i), .request_i(req), .cgs_active_i(cgs_active_o), .sync_n_o(snc));
  initial forever #5 mclk_i = ~mclk_i;
  task chk(input logic s, input logic e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: %h expected %h", $time, s, e);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task t_misc;
    @(posedge mclk_i);
    {timestamp_receiver_enable_i, timestamp_enable_i, pin, serial_read_active_i, serial_read_bit_i, sysref_i} <= 6'h37;
    @(posedge mclk_i);
    #1;
    chk(timestamp_o, 1);
    chk(serial_read_output_oe_o, 1);
    chk(serial_read_output_o, 1);
    chk(sysref_mark_o, 1);
    @(posedge mclk_i);
    {pin, serial_read_active_i, sysref_i} <= 3'h4;
    repeat (2) @(posedge mclk_i);
    #1;
    chk(serial_read_output_oe_o, 0);
    chk(timestamp_o, 0);
    chk(sysref_mark_o, 0);
    $display("misc test done");
  endtask
  task t_off;
    @(posedge mclk_i);
    {sync_select_i, timestamp_receiver_enable_i, pin} <= 3'h4;
    repeat (10) @(posedge mclk_i);
    #1;
    chk(cgs_active_o, 0);
    chk(timestamp_o, 0);
    $display("receiver off test done");
  endtask
  task t_link(input logic s);
    @(posedge mclk_i);
    {sync_select_i, timestamp_receiver_enable_i, pin, req} <= {s, 3'h7};
    for (int i = 0; i < 40 && cgs_active_o !== 1; i++) @(posedge mclk_i);
    for (int i = 0; i < 40 && link_data_o !== 1; i++) @(posedge mclk_i);
    #1;
    chk(link_data_o, 1);
    chk(ilas_active_o, 0);
    @(posedge mclk_i);
    req <= 0;
    $display("link test done");
  endtask
  initial begin
    repeat (12) @(posedge mclk_i);
    reset_i <= 0;
    t_misc;
    t_off;
    t_link(0);
    t_link(1);
    report_and_stop;
  end
  initial begin
    #20000;
    n_fail++;
    report_and_stop;
  end
endmodule
